// *** core/dac_power_down_control.sv ***
// Power-down controller for a two channel voltage-output converter.
// Assumes an APB master on clk_sys; the latch input comes from a pin.
`timescale 1ns/100ps
module dac_power_down_control
  import dac_pd_pkg::*;
#(
  parameter int BITS = 12
)(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Latch inhibit pin, active high inhibits
  input wire logic latch_inhibit_input,
  // Per-channel analog controls
  output logic [1:0] ampEnable,
  output logic [1:0] ladderEnable,
  output logic [1:0] refBufEnable,
  output logic [1:0] bandGapEnable,
  output logic [1:0] pull1kEnable,
  output logic [1:0] pull100kEnable,
  output logic [2*BITS-1:0] wiperCode,
  output logic [1:0] gainSelect
);

  typedef enum logic [1:0] {ST_NORMAL, ST_ENTER, ST_DOWN, ST_EXIT} chan_state_t;

  typedef struct packed {
    logic [1:0] rstSync;
    logic [2:0] latSync;
    logic latched;
    logic [3:0] powerDownSelect;
    logic [3:0] nvPowerDown;
    logic [7:0] config_;
    logic [7:0] nvConfig;
    logic [2*BITS-1:0] data;
    logic [2*BITS-1:0] nvData;
    logic [2*BITS-1:0] wiper;
    logic [15:0] entryCycles;
    logic [15:0] exitCycles;
    chan_state_t [1:0] state;
    logic [1:0][15:0] count;
    logic [1:0] driving;
    logic [31:0] rdata;
  } state_t;

  state_t cur_ff, nxt_ff;
  logic rstIn_n;
  logic access;
  logic wrEn;

  // Reset release through three flip-flops
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rstIn_n <= 1'b0;
    else
      rstIn_n <= cur_ff.rstSync[1];
  end

  assign access = psel && penable;
  assign wrEn = access && pwrite;
  assign pready = 1'b1;
  assign prdata = cur_ff.rdata;

  // Unmapped offsets answer with an error
  always_comb
  begin
    pslverr = 1'b0;
    if (access)
    begin
      case (paddr)
        OFF_DATA0, OFF_DATA1, OFF_PD, OFF_CFG, OFF_NVPD, OFF_CMD, OFF_STAT,
        OFF_WIPER0, OFF_WIPER1, OFF_DELAY: pslverr = 1'b0;
        default: pslverr = 1'b1;
      endcase
    end
  end

  // Next state of the whole controller
  always_comb
  begin
    logic [1:0] pdc;
    logic gcReset;
    logic gcWake;
    nxt_ff = cur_ff;
    pdc = 2'b00;
    nxt_ff.rstSync = {cur_ff.rstSync[0], 1'b1};
    nxt_ff.latSync = {cur_ff.latSync[1:0], latch_inhibit_input};
    if (cur_ff.latSync[2] == cur_ff.latSync[1])
      nxt_ff.latched = cur_ff.latSync[2];
    gcReset = wrEn && paddr == OFF_CMD && pwdata[CMD_GC_RESET];
    gcWake = wrEn && paddr == OFF_CMD && pwdata[CMD_GC_WAKE];
    // Register writes; serial path never gated by mode
    if (wrEn)
    begin
      case (paddr)
        OFF_DATA0: nxt_ff.data[BITS-1:0] = pwdata[BITS-1:0];
        OFF_DATA1: nxt_ff.data[2*BITS-1:BITS] = pwdata[BITS-1:0];
        OFF_PD: nxt_ff.powerDownSelect = pwdata[3:0];
        OFF_CFG: nxt_ff.config_ = pwdata[7:0];
        OFF_NVPD:
        begin
          nxt_ff.nvPowerDown = pwdata[3:0];
          nxt_ff.nvConfig = pwdata[15:8];
        end
        OFF_DELAY:
        begin
          nxt_ff.entryCycles = pwdata[15:0];
          nxt_ff.exitCycles = pwdata[31:16];
        end
        default: ;
      endcase
    end
    // Wake-up clears both modes
    if (gcWake)
      nxt_ff.powerDownSelect = 4'h0;
    // General-call reset clears modes and reloads config and data from nonvolatile copy
    if (gcReset)
    begin
      nxt_ff.powerDownSelect = 4'h0;
      nxt_ff.config_ = cur_ff.nvConfig;
      nxt_ff.data = cur_ff.nvData;
    end
    // Wiper follows data only while latch is low
    if (!cur_ff.latched)
      nxt_ff.wiper = cur_ff.data;
    // Per-channel entry and exit sequencing
    for (int c = 0; c < 2; c++)
    begin
      pdc = cur_ff.powerDownSelect[2*c +: 2];
      case (cur_ff.state[c])
        ST_NORMAL:
          if (pdc != PD_NORMAL)
          begin
            nxt_ff.state[c] = ST_ENTER;
            nxt_ff.count[c] = cur_ff.entryCycles;
          end
        ST_ENTER:
          if (pdc == PD_NORMAL)
            nxt_ff.state[c] = ST_NORMAL;
          else if (cur_ff.count[c] <= 16'h0001)
          begin
            nxt_ff.state[c] = ST_DOWN;
            nxt_ff.driving[c] = 1'b0;
          end
          else
            nxt_ff.count[c] = cur_ff.count[c] - 16'h0001;
        ST_DOWN:
          if (pdc == PD_NORMAL)
          begin
            nxt_ff.state[c] = ST_EXIT;
            nxt_ff.count[c] = cur_ff.exitCycles;
          end
        ST_EXIT:
          if (pdc != PD_NORMAL)
            nxt_ff.state[c] = ST_DOWN;
          else if (cur_ff.count[c] <= 16'h0001)
          begin
            nxt_ff.state[c] = ST_NORMAL;
            nxt_ff.driving[c] = 1'b1;
          end
          else
            nxt_ff.count[c] = cur_ff.count[c] - 16'h0001;
        default: nxt_ff.state[c] = ST_NORMAL;
      endcase
    end
    // Read data
    nxt_ff.rdata = 32'h0000_0000;
    if (psel && !penable && !pwrite)
    begin
      case (paddr)
        OFF_DATA0: nxt_ff.rdata = 32'(cur_ff.data[BITS-1:0]);
        OFF_DATA1: nxt_ff.rdata = 32'(cur_ff.data[2*BITS-1:BITS]);
        OFF_PD: nxt_ff.rdata = {28'h000_0000, cur_ff.powerDownSelect};
        OFF_CFG: nxt_ff.rdata = {24'h00_0000, cur_ff.config_};
        OFF_NVPD: nxt_ff.rdata = {16'h0000, cur_ff.nvConfig, 4'h0, cur_ff.nvPowerDown};
        OFF_STAT: nxt_ff.rdata = {27'h000_0000, cur_ff.latched, 2'b00, cur_ff.driving};
        OFF_WIPER0: nxt_ff.rdata = 32'(cur_ff.wiper[BITS-1:0]);
        OFF_WIPER1: nxt_ff.rdata = 32'(cur_ff.wiper[2*BITS-1:BITS]);
        OFF_DELAY: nxt_ff.rdata = {cur_ff.exitCycles, cur_ff.entryCycles};
        default: nxt_ff.rdata = 32'h0000_0000;
      endcase
    end
    // Power-on load copies nonvolatile mode
    if (!cur_ff.rstSync[1])
    begin
      nxt_ff.powerDownSelect = cur_ff.nvPowerDown;
      nxt_ff.config_ = cur_ff.nvConfig;
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur_ff <= '0;
      cur_ff.entryCycles <= ENTRY_CYCLES;
      cur_ff.exitCycles <= EXIT_CYCLES;
      cur_ff.driving <= 2'b11;
      cur_ff.powerDownSelect <= PD_RESET;
      cur_ff.config_ <= CFG_RESET;
    end
    else if (!rstIn_n)
    begin
      cur_ff <= nxt_ff;
      cur_ff.rdata <= 32'h0000_0000;
    end
    else
      cur_ff <= nxt_ff;
  end

  // Enable decode per channel and reference
  always_comb
  begin
    logic [1:0] pd;
    logic [1:0] rs;
    pd = 2'b00;
    rs = 2'b00;
    for (int c = 0; c < 2; c++)
    begin
      pd = cur_ff.powerDownSelect[2*c +: 2];
      rs = cur_ff.config_[2*c +: 2];
      gainSelect[c] = cur_ff.config_[4+c];
      ampEnable[c] = cur_ff.driving[c];
      if (cur_ff.driving[c])
      begin
        ladderEnable[c] = rs != REF_PIN_UNBUF;
        refBufEnable[c] = rs == REF_BANDGAP || rs == REF_PIN_BUF;
        bandGapEnable[c] = rs == REF_BANDGAP;
        pull1kEnable[c] = 1'b0;
        pull100kEnable[c] = 1'b0;
      end
      else
      begin
        ladderEnable[c] = 1'b0;
        refBufEnable[c] = 1'b0;
        bandGapEnable[c] = rs == REF_BANDGAP;
        pull1kEnable[c] = pd == PD_PULL_1K;
        pull100kEnable[c] = pd == PD_PULL_100K;
      end
    end
  end

  assign wiperCode = cur_ff.wiper;

  // Checks on mode register and command decode
  pd_write_a: assert property (@(posedge clk_sys) disable iff (!rstIn_n)
    wrEn && paddr == OFF_PD |=> cur_ff.powerDownSelect == $past(pwdata[3:0])
      || $past(!cur_ff.rstSync[1]))
    else $error("mode write lost");
  wake_clear_a: assert property (@(posedge clk_sys) disable iff (!rstIn_n)
    wrEn && paddr == OFF_CMD && pwdata[CMD_GC_WAKE] |=> cur_ff.powerDownSelect == 4'h0)
    else $error("wake left power-down");
  mode_hold_a: assert property (@(posedge clk_sys) disable iff (!rstIn_n)
    !(wrEn && (paddr == OFF_PD || paddr == OFF_CMD)) |=> $stable(cur_ff.powerDownSelect))
    else $error("mode changed without a command");
  gc_reset_a: assert property (@(posedge clk_sys) disable iff (!rstIn_n)
    wrEn && paddr == OFF_CMD && pwdata[CMD_GC_RESET] |=> cur_ff.powerDownSelect == 4'h0
      && cur_ff.config_ == $past(cur_ff.nvConfig) && cur_ff.data == $past(cur_ff.nvData))
    else $error("general-call reset load");

  // Checks on entry and exit sequencing, both channels
  entry_delay_a: assert property (@(posedge clk_sys) disable iff (!rstIn_n)
    cur_ff.state[0] == ST_NORMAL && cur_ff.powerDownSelect[1:0] != PD_NORMAL
      && cur_ff.entryCycles > 16'h0001 |=> ampEnable[0])
    else $error("amplifier dropped early");
  entry_far_a: assert property (@(posedge clk_sys) disable iff (!rstIn_n)
    cur_ff.state[1] == ST_NORMAL && cur_ff.powerDownSelect[3:2] != PD_NORMAL
      && cur_ff.entryCycles > 16'h0001 |=> ampEnable[1])
    else $error("far amplifier dropped early");
  entry_end_a: assert property (@(posedge clk_sys) disable iff (!rstIn_n)
    cur_ff.state[1] == ST_ENTER && cur_ff.count[1] <= 16'h0001
      && cur_ff.powerDownSelect[3:2] != PD_NORMAL |=> !ampEnable[1])
    else $error("amplifier kept after entry delay");
  exit_delay_a: assert property (@(posedge clk_sys) disable iff (!rstIn_n)
    cur_ff.state[0] == ST_DOWN && cur_ff.powerDownSelect[1:0] == PD_NORMAL
      && cur_ff.exitCycles > 16'h0001 |=> !ampEnable[0])
    else $error("amplifier enabled early");
  exit_end_a: assert property (@(posedge clk_sys) disable iff (!rstIn_n)
    cur_ff.state[1] == ST_EXIT && cur_ff.count[1] <= 16'h0001
      && cur_ff.powerDownSelect[3:2] == PD_NORMAL |=> ampEnable[1])
    else $error("amplifier late after exit delay");

  // Checks on the enable decode
  down_off_a: assert property (@(posedge clk_sys) disable iff (!rstIn_n)
    !ampEnable[1] |-> !ladderEnable[1] && !refBufEnable[1])
    else $error("circuits on in power-down");
  down_bg_a: assert property (@(posedge clk_sys) disable iff (!rstIn_n)
    !ampEnable[0] |-> bandGapEnable[0] == (cur_ff.config_[1:0] == REF_BANDGAP) && !refBufEnable[0])
    else $error("power-down band gap decode");
  pull_sel_a: assert property (@(posedge clk_sys) disable iff (!rstIn_n)
    pull1kEnable[0] |-> !ampEnable[0] && cur_ff.powerDownSelect[1:0] == PD_PULL_1K)
    else $error("wrong pull-down");
  pull_far_a: assert property (@(posedge clk_sys) disable iff (!rstIn_n)
    pull100kEnable[1] |-> !ampEnable[1] && cur_ff.powerDownSelect[3:2] == PD_PULL_100K)
    else $error("wrong far pull-down");
  open_mode_a: assert property (@(posedge clk_sys) disable iff (!rstIn_n)
    !ampEnable[0] && cur_ff.powerDownSelect[1:0] == PD_OPEN |-> !pull1kEnable[0] && !pull100kEnable[0])
    else $error("pull-down in open mode");
  normal_pull_a: assert property (@(posedge clk_sys) disable iff (!rstIn_n)
    ampEnable[1] |-> !pull1kEnable[1] && !pull100kEnable[1]
      && ladderEnable[1] == (cur_ff.config_[3:2] != REF_PIN_UNBUF))
    else $error("pull-down while driving");
  normal_bg_a: assert property (@(posedge clk_sys) disable iff (!rstIn_n)
    ampEnable[0] |-> bandGapEnable[0] == (cur_ff.config_[1:0] == REF_BANDGAP))
    else $error("band gap decode");

  // Checks on data and wiper
  latch_hold_a: assert property (@(posedge clk_sys) disable iff (!rstIn_n)
    cur_ff.latched ##1 cur_ff.latched |-> $stable(cur_ff.wiper))
    else $error("wiper moved while latched");
  wiper_follow_a: assert property (@(posedge clk_sys) disable iff (!rstIn_n)
    !cur_ff.latched |=> cur_ff.wiper == $past(cur_ff.data))
    else $error("wiper missed the data");
  keep_data_a: assert property (@(posedge clk_sys) disable iff (!rstIn_n)
    !ampEnable[0] && !wrEn |=> $stable(cur_ff.data))
    else $error("data lost in power-down");

endmodule

// *** dv/apb_host.sv ***
// APB host model that drives the register port of the power-down controller.
// Assumes one clock; every request starts just after a rising edge.
`timescale 1ns/100ps
module apb_host (
  // Clock
  input wire logic clk_sys,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus at time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  // Setup, then access held until pready is sampled high
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
    begin
      @(posedge clk_sys);
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released address and data lines carry the inverse, never the old value
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// *** dv/tb.sv ***
// Self-checking bench for the converter power-down controller.
// Assumes the APB host model and the package constants; delays set to 2 cycles.
`timescale 1ns/100ps
module tb;
  import dac_pd_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic latchIn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [1:0] ampEnable, ladderEnable, refBufEnable, bandGapEnable, pull1kEnable, pull100kEnable, gainSelect;
  logic [23:0] wiperCode;
  logic err;
  int fail_count = 0;
  int checks = 0;
  int seed = 57782;

  // 40 MHz clock
  always #12.5 clk_sys = ~clk_sys;

  dac_power_down_control u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .latch_inhibit_input(latchIn), .ampEnable(ampEnable), .ladderEnable(ladderEnable),
    .refBufEnable(refBufEnable), .bandGapEnable(bandGapEnable), .pull1kEnable(pull1kEnable),
    .pull100kEnable(pull100kEnable), .wiperCode(wiperCode), .gainSelect(gainSelect));

  apb_host u_host (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // Compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q, err);
  endtask

  task automatic rd(input logic [11:0] a);
    u_host.xfer(1'b0, a, 32'h0000_0000, q, err);
  endtask

  // Expected enables {amp, ladder, buffer, band gap, 1k, 100k}
  function automatic logic [31:0] expEn(logic [1:0] m, logic [1:0] r);
    if (m == PD_NORMAL)
      return {26'h0, 1'b1, r != REF_PIN_UNBUF, r == REF_BANDGAP || r == REF_PIN_BUF, r == REF_BANDGAP, 2'b00};
    return {26'h0, 3'b000, r == REF_BANDGAP, m == PD_PULL_1K, m == PD_PULL_100K};
  endfunction

  function automatic logic [31:0] seenEn(int c);
    return {26'h0, ampEnable[c], ladderEnable[c], refBufEnable[c], bandGapEnable[c], pull1kEnable[c],
            pull100kEnable[c]};
  endfunction

  task automatic end_sim;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    end_sim();
  end

  // Main sequence
  initial
  begin
    logic [1:0] m, g, r1;
    logic [31:0] d;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    wr(OFF_DELAY, 32'h0002_0002);
    rd(OFF_PD);
    chk("pd after reset", q, 32'h0000_0000);
    for (int r = 0; r < 4; r++)
    begin
      r1 = 2'(3 - r);
      g = 2'($random(seed)) & {r1 != REF_SUPPLY, r != 0};
      wr(OFF_CFG, {26'h0, g, r1, 2'(r)});
      d = {20'h0, 12'($random(seed)) | 12'h001};
      wr(OFF_DATA0, d);
      repeat (6) @(posedge clk_sys);
      chk("normal ch0", seenEn(0), expEn(PD_NORMAL, 2'(r)));
      chk("gain", {30'h0, gainSelect}, {30'h0, g});
      m = 2'(r % 3 + 1);
      wr(OFF_PD, {30'h0, m});
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("entry pending", {31'h0, ampEnable[0]}, 32'h0000_0001);
      @(negedge clk_sys);
      chk("entry done", {31'h0, ampEnable[0]}, 32'h0000_0000);
      repeat (8) @(posedge clk_sys);
      chk("down ch0", seenEn(0), expEn(m, 2'(r)));
      chk("other ch1", seenEn(1), expEn(PD_NORMAL, r1));
      rd(OFF_DATA0);
      chk("data kept", q, d);
      chk("mapped err", {31'h0, err}, 32'h0000_0000);
      rd(OFF_PD);
      chk("pd read", q, {30'h0, m});
      if (r[0])
        wr(OFF_CMD, 32'h0000_0002);
      else
        wr(OFF_PD, 32'h0000_0000);
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("exit pending", {31'h0, ampEnable[0]}, 32'h0000_0000);
      @(negedge clk_sys);
      chk("exit done", {31'h0, ampEnable[0]}, 32'h0000_0001);
      repeat (8) @(posedge clk_sys);
      chk("exit ch0", seenEn(0), expEn(PD_NORMAL, 2'(r)));
    end
    // Nonvolatile setting stored while channels run, never while both are down
    wr(OFF_NVPD, 32'h0000_1D00);
    // Both down, then general-call reset restores the nonvolatile copy
    wr(OFF_PD, 32'h0000_0009);
    repeat (8) @(posedge clk_sys);
    chk("ch0 down", seenEn(0), expEn(PD_PULL_1K, REF_PIN_BUF));
    chk("ch1 down", seenEn(1), expEn(PD_PULL_100K, REF_SUPPLY));
    wr(OFF_CMD, 32'h0000_0001);
    repeat (10) @(posedge clk_sys);
    rd(OFF_PD);
    chk("gc reset pd", q, 32'h0000_0000);
    rd(OFF_CFG);
    chk("gc reset cfg", q, 32'h0000_001D);
    chk("gc reset gain", {30'h0, gainSelect}, 32'h0000_0001);
    chk("gc reset ch0", seenEn(0), expEn(PD_NORMAL, REF_BANDGAP));
    chk("gc reset ch1", seenEn(1), expEn(PD_NORMAL, REF_PIN_BUF));
    rd(OFF_DATA0);
    chk("gc reset data", q, 32'h0000_0000);
    // Latch held high blocks the wiper, release lets it follow
    latchIn <= 1'b1;
    repeat (6) @(posedge clk_sys);
    d = {20'h0, 12'($random(seed)) | 12'h001};
    wr(OFF_DATA0, d);
    repeat (8) @(posedge clk_sys);
    chk("wiper held", {20'h0, wiperCode[11:0]}, 32'h0000_0000);
    latchIn <= 1'b0;
    repeat (8) @(posedge clk_sys);
    chk("wiper moved", {20'h0, wiperCode[11:0]}, d);
    rd(12'hFFC);
    chk("unmapped", q, 32'h0000_0000);
    chk("unmapped err", {31'h0, err}, 32'h0000_0001);
    end_sim();
  end

endmodule

// *** inc/dac_pd_pkg.sv ***
// Constants for the converter power-down controller.
// Assumes a 40 MHz system clock and an APB register port.
package dac_pd_pkg;
  localparam int CLK_MHZ = 40;
  localparam int ENTRY_DELAY_NS = 10000;
  localparam int EXIT_DELAY_NS = 10000;
  localparam logic [15:0] ENTRY_CYCLES = 16'((ENTRY_DELAY_NS * CLK_MHZ) / 1000);
  localparam logic [15:0] EXIT_CYCLES = 16'((EXIT_DELAY_NS * CLK_MHZ) / 1000);
  localparam logic [1:0] PD_NORMAL = 2'h0;
  localparam logic [1:0] PD_PULL_1K = 2'h1;
  localparam logic [1:0] PD_PULL_100K = 2'h2;
  localparam logic [1:0] PD_OPEN = 2'h3;
  localparam logic [1:0] REF_SUPPLY = 2'h0;
  localparam logic [1:0] REF_BANDGAP = 2'h1;
  localparam logic [1:0] REF_PIN_UNBUF = 2'h2;
  localparam logic [1:0] REF_PIN_BUF = 2'h3;
  localparam logic [11:0] OFF_DATA0 = 12'h000;
  localparam logic [11:0] OFF_DATA1 = 12'h004;
  localparam logic [11:0] OFF_PD = 12'h008;
  localparam logic [11:0] OFF_CFG = 12'h00C;
  localparam logic [11:0] OFF_NVPD = 12'h010;
  localparam logic [11:0] OFF_CMD = 12'h014;
  localparam logic [11:0] OFF_STAT = 12'h018;
  localparam logic [11:0] OFF_WIPER0 = 12'h01C;
  localparam logic [11:0] OFF_WIPER1 = 12'h020;
  localparam logic [11:0] OFF_DELAY = 12'h024;
  localparam int CMD_GC_RESET = 0;
  localparam int CMD_GC_WAKE = 1;
  localparam logic [3:0] PD_RESET = 4'h0;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [11:0] DATA_RESET = 12'h000;
endpackage
